/* File: src/col_addr_reg.sv */
// column address holding register
`timescale 1ns/100ps
`include "dram_ctl_defines.svh"
module col_addr_reg (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // load side
    input  wire logic              load_i,
    input  wire logic [`COL_W-1:0] addr_i,
    // held value
    output logic      [`COL_W-1:0] addr_o
);
    logic [`COL_W-1:0] addr_q;
    logic [`COL_W-1:0] addr_d;

    always_comb begin
        addr_d = load_i ? addr_i : addr_q;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    assign addr_o = addr_q;
endmodule // col_addr_reg

/* File: src/dram_ctl_defines.svh */
// constants for the pipelined dram read controller
`ifndef DRAM_CTL_DEFINES_SVH
`define DRAM_CTL_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    20
`define DELAYED_CLOCK_DELAY_NS    20
`define DELAYED_CLOCK_DELAY_CYC   ((`DELAYED_CLOCK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RDL_AFTER_CAE    2
`define PRECHARGE_CLKS   3

// ----------------------------------------------------------------
// widths and limits
// ----------------------------------------------------------------
`define NUM_BANKS        4
`define NUM_LANES        8
`define COL_W            10
`define BANK_W           3
`define STATE_W          5
`define CNT_W            2
`define MAX_PENDING      2'h3
`define PARITY_BANK_BIT  2

`endif

/* File: src/dram_ctl_pkg.sv */
// types for the pipelined dram read controller
package dram_ctl_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h00,
        ST_ROW  = 5'h01,
        ST_RAS  = 5'h02,
        ST_COL  = 5'h03,
        ST_DAT  = 5'h04,
        ST_LAT  = 5'h05,
        ST_DONE = 5'h06,
        ST_PRE  = 5'h07,
        ST_WCOL = 5'h0A,
        ST_WCS  = 5'h0B
    } state_t;
endpackage

/* File: src/dram_read_ctl.sv */
// bus-tracking page-mode dram controller with pipelined reads
`timescale 1ns/100ps
`include "dram_ctl_defines.svh"
module dram_read_ctl
    import dram_ctl_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // processor side
    input  wire logic                  addr_strobe_n_i,
    input  wire logic                  memory_select_decode_i,
    input  wire logic                  write_not_read_i,
    input  wire logic                  cacheable_i,
    input  wire logic                  same_page_i,
    input  wire logic [`BANK_W-1:0]    bank_addr_i,
    input  wire logic [`COL_W-1:0]     col_addr_i,
    input  wire logic [`NUM_LANES-1:0] byte_lane_enables_n_i,
    output logic                       cycle_done_n_o,
    output logic                       cycle_done_oe_o,
    output logic                       next_addr_out_n_o,
    output logic                       next_addr_oe_o,
    output logic                       cache_enable_n_o,
    output logic                       bus_hold_n_o,
    // address and data path
    output logic                       row_path_enable_n_o,
    output logic                       col_path_enable_n_o,
    output logic                       col_addr_latch_o,
    output logic      [`COL_W-1:0]     col_addr_o,
    output logic                       read_data_latch_o,
    output logic                       write_data_latch_o,
    output logic                       xcvr_direction_o,
    output logic                       xcvr_drive_enable_n_o,
    // memory banks
    output logic      [`NUM_BANKS-1:0] chip_select_n_o,
    output logic      [`NUM_BANKS-1:0] output_enable_n_o,
    output logic      [`NUM_BANKS-1:0] row_strobe_n_o,
    output logic                       parity_row_strobe_n_o,
    output logic      [`NUM_LANES-1:0] byte_write_enables_o,
    output logic                       write_enable_latch_clk_o,
    // controller status
    output logic                       latched_addr_strobe_n_o,
    output logic                       cycle_pending_n_o,
    output logic      [`STATE_W-1:0]   state_vars_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t                state_q, state_d;
    logic                  latched_addr_strobe_n_q, latched_addr_strobe_n_d;
    logic                  latched_addr_strobe_n_prev_q, latched_addr_strobe_n_prev_d;
    logic [`CNT_W-1:0]     pend_q, pend_d;
    logic [`CNT_W-1:0]     pre_q, pre_d;
    logic                  first_q, first_d;
    logic                  wr_q, wr_d;
    logic [`BANK_W-1:0]    bank_q, bank_d;
    logic                  cs_q, cs_d;
    logic                  oe_q, oe_d;
    logic [`NUM_LANES-1:0] we_q, we_d;
    logic                  pend_set;
    logic                  pending_clear;
    logic                  done;
    logic                  na;
    logic                  ras_on;
    logic                  write_enable_latch_clk;

    // ------------------------------------------------------------
    // strobe latch and pending count
    // ------------------------------------------------------------
    always_comb begin
        latched_addr_strobe_n_d      = ~addr_strobe_n_i;
        latched_addr_strobe_n_prev_d = latched_addr_strobe_n_q;
        pend_set    = latched_addr_strobe_n_prev_q                            // per strobe
                      & memory_select_decode_i;
        pend_d      = pend_q;
        if (pend_set && !pending_clear) begin
            pend_d = pend_q + 2'h1;
        end else if (!pend_set && pending_clear && pend_q != '0) begin
            pend_d = pend_q - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            latched_addr_strobe_n_q      <= 1'b0;
            latched_addr_strobe_n_prev_q <= 1'b0;
            pend_q      <= '0;
        end else begin
            latched_addr_strobe_n_q      <= latched_addr_strobe_n_d;
            latched_addr_strobe_n_prev_q <= latched_addr_strobe_n_prev_d;
            pend_q      <= pend_d;
        end
    end

    // ------------------------------------------------------------
    // bus tracking state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        pre_d   = pre_q;
        first_d = first_q;
        wr_d    = wr_q;
        bank_d  = bank_q;
        unique case (state_q)
            ST_IDLE: begin
                if (pend_q != '0) begin
                    state_d = ST_ROW;
                    wr_d    = write_not_read_i;
                    bank_d  = bank_addr_i;
                    first_d = 1'b1;
                end
            end
            ST_ROW:  state_d = ST_RAS;
            ST_RAS:  state_d = wr_q ? ST_WCOL : ST_COL;
            ST_COL:  state_d = ST_DAT;
            ST_DAT:  state_d = ST_LAT;
            ST_LAT:  state_d = ST_DONE;
            ST_DONE: begin
                first_d = 1'b0;
                if (pend_q > 2'h1 && same_page_i
                    && !write_not_read_i) begin
                    state_d = ST_COL;
                end else begin
                    state_d = ST_PRE;
                    pre_d   = '0;
                end
            end
            ST_WCOL: state_d = ST_WCS;
            ST_WCS: begin
                state_d = ST_PRE;
                pre_d   = '0;
            end
            ST_PRE: begin
                pre_d = pre_q + 2'h1;
                if (pre_q == 2'(`PRECHARGE_CLKS - 1)) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            pre_q   <= '0;
            first_q <= 1'b0;
            wr_q    <= 1'b0;
            bank_q  <= '0;
        end else begin
            state_q <= state_d;
            pre_q   <= pre_d;
            first_q <= first_d;
            wr_q    <= wr_d;
            bank_q  <= bank_d;
        end
    end

    // ------------------------------------------------------------
    // processor side decode
    // ------------------------------------------------------------
    always_comb begin
        done = (state_q == ST_DONE) || (state_q == ST_WCOL);
        pending_clear = done;
        na = !wr_q && pend_q < `MAX_PENDING &&
             ((first_q && (state_q == ST_COL || state_q == ST_LAT))
              || state_q == ST_DONE);
    end

    assign cycle_done_n_o    = ~done;
    assign cycle_done_oe_o   = done;
    assign next_addr_out_n_o = ~na;
    assign next_addr_oe_o    = na;
    assign cache_enable_n_o  = ~(cacheable_i && !wr_q
                                 && (na || done));
    assign bus_hold_n_o      = ~(state_q != ST_IDLE
                                 || pend_q != '0);
    assign latched_addr_strobe_n_o = ~latched_addr_strobe_n_q;
    assign cycle_pending_n_o = (pend_q == '0);
    assign state_vars_o      = state_q;

    // ------------------------------------------------------------
    // address and data path controls
    // ------------------------------------------------------------
    always_comb begin
        ras_on = state_q inside {ST_RAS, ST_COL, ST_DAT, ST_LAT,
                                 ST_DONE, ST_WCOL, ST_WCS};
        write_enable_latch_clk    = (state_q == ST_WCOL);
    end

    assign row_path_enable_n_o = ~(state_q inside
                                   {ST_IDLE, ST_ROW, ST_RAS,
                                    ST_PRE});
    assign col_path_enable_n_o = ~(state_q inside
                                   {ST_COL, ST_DAT, ST_LAT,
                                    ST_DONE, ST_WCOL,
                                    ST_WCS});
    assign col_addr_latch_o    = (state_q == ST_COL)
                                 || (state_q == ST_WCOL);
    assign read_data_latch_o   = (state_q == ST_LAT);
    assign write_data_latch_o  = (state_q == ST_WCOL);
    assign xcvr_direction_o    = ~wr_q;
    assign xcvr_drive_enable_n_o = ~((state_q == ST_DONE)
                                     || (state_q == ST_WCS));
    assign write_enable_latch_clk_o = write_enable_latch_clk;

    col_addr_reg u_col_addr_reg (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .load_i  (col_addr_latch_o),
        .addr_i  (col_addr_i),
        .addr_o  (col_addr_o)
    );

    // ------------------------------------------------------------
    // bank strobes, chip select, output and write enables
    // ------------------------------------------------------------
    always_comb begin
        // delayed-clock copy: registered on clk_i from the next state, so it follows the state in the same clock
        cs_d = state_d inside {ST_COL, ST_DAT, ST_LAT, ST_DONE,
                               ST_WCS};
        oe_d = !wr_d && (state_d inside {ST_COL, ST_DAT,
                                          ST_LAT, ST_DONE});
        we_d = we_q;
        if (write_enable_latch_clk) begin
            we_d = ~byte_lane_enables_n_i;
        end else if (state_q == ST_IDLE) begin
            we_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_q <= 1'b0;
            oe_q <= 1'b0;
            we_q <= '0;
        end else begin
            cs_q <= cs_d;
            oe_q <= oe_d;
            we_q <= we_d;
        end
    end

    genvar b;
    generate
        for (b = 0; b < `NUM_BANKS; b++) begin : g_bank
            assign chip_select_n_o[b]   = ~cs_q;
            assign output_enable_n_o[b] = ~oe_q;
            assign row_strobe_n_o[b]    = ~(ras_on &&
                bank_q == `BANK_W'(b));
        end
    endgenerate

    assign parity_row_strobe_n_o = ~(ras_on &&
                                     !bank_q[`PARITY_BANK_BIT]);
    assign byte_write_enables_o  = we_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rdl_after_cae;
        @(posedge clk_i) disable iff (reset_i)
        (state_q == ST_COL) |-> ##2 read_data_latch_o;
    endproperty
    a_rdl_after_cae: assert property (p_rdl_after_cae)
        else $error("read latch not two clocks after column enable");

    property p_done_after_rdl;
        @(posedge clk_i) disable iff (reset_i)
        read_data_latch_o |=> !cycle_done_n_o && cycle_done_oe_o;
    endproperty
    a_done_after_rdl: assert property (p_done_after_rdl)
        else $error("done missing after read latch");

    property p_paths_exclusive;
        @(posedge clk_i) disable iff (reset_i)
        !(!row_path_enable_n_o && !col_path_enable_n_o);
    endproperty
    a_paths_exclusive: assert property (p_paths_exclusive)
        else $error("row and column paths both enabled");

    property p_col_cs_together;
        @(posedge clk_i) disable iff (reset_i)
        $fell(col_path_enable_n_o) |->
            col_addr_latch_o && $rose(row_path_enable_n_o)
            && (wr_q || chip_select_n_o == 4'h0);
    endproperty
    a_col_cs_together: assert property (p_col_cs_together)
        else $error("column enable, latch, select not aligned");

    property p_ras_holds_path;
        @(posedge clk_i) disable iff (reset_i)
        $fell(parity_row_strobe_n_o) && !row_path_enable_n_o
        |-> !row_path_enable_n_o ##1 row_path_enable_n_o;
    endproperty
    a_ras_holds_path: assert property (p_ras_holds_path)
        else $error("row path not held one clock past row strobe");

    property p_precharge;
        @(posedge clk_i) disable iff (reset_i)
        (state_q == ST_DONE) && (state_d == ST_PRE) |=>
            (row_strobe_n_o == 4'hF)[*3] ##1 (state_q == ST_IDLE);
    endproperty
    a_precharge: assert property (p_precharge)
        else $error("precharge wait not three clocks");

    property p_na_limit;
        @(posedge clk_i) disable iff (reset_i)
        !next_addr_out_n_o |-> pend_q < `MAX_PENDING;
    endproperty
    a_na_limit: assert property (p_na_limit)
        else $error("next address with three cycles pending");

    property p_na_first_read;
        @(posedge clk_i) disable iff (reset_i)
        (state_q == ST_COL) && first_q && !next_addr_out_n_o |->
            ##2 !next_addr_out_n_o ##1 !cycle_done_n_o;
    endproperty
    a_na_first_read: assert property (p_na_first_read)
        else $error("next address timing wrong in first read");

    property p_one_bank;
        @(posedge clk_i) disable iff (reset_i)
        $countones(~row_strobe_n_o) <= 1;
    endproperty
    a_one_bank: assert property (p_one_bank)
        else $error("more than one bank strobed");

    property p_wel_only_write;
        @(posedge clk_i) disable iff (reset_i)
        write_enable_latch_clk_o |-> wr_q ##1
            byte_write_enables_o == $past(~byte_lane_enables_n_i);
    endproperty
    a_wel_only_write: assert property (p_wel_only_write)
        else $error("write enable latch outside write or wrong data");

    property p_post_write;
        @(posedge clk_i) disable iff (reset_i)
        write_data_latch_o |-> !cycle_done_n_o
            ##1 chip_select_n_o == 4'h0;
    endproperty
    a_post_write: assert property (p_post_write)
        else $error("write not posted before chip select");

    property p_hold_busy;
        @(posedge clk_i) disable iff (reset_i)
        (pend_q != '0) |-> !bus_hold_n_o;
    endproperty
    a_hold_busy: assert property (p_hold_busy)
        else $error("bus hold released with cycles pending");
endmodule // dram_read_ctl

/* File: tb/pipelined_dram_read_controller_bench.sv */
// self-checking bench for the pipelined dram read controller
`timescale 1ns/100ps
`include "dram_ctl_defines.svh"
module pipelined_dram_read_controller_bench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0, reset_i = 1'b1, go_req = 1'b0, fill_req = 1'b0;
    logic addr_strobe_n_i, memory_select_decode_i = 1'b1;
    logic write_not_read_i = 1'b0, cacheable_i = 1'b0, same_page_i = 1'b1;
    logic [`BANK_W-1:0] bank_addr_i = 3'h0;
    logic [`COL_W-1:0] col_addr_i = 10'h000, col_addr_o;
    logic [`NUM_LANES-1:0] byte_lane_enables_n_i = 8'hFF, byte_write_enables_o;
    logic cycle_done_n_o, cycle_done_oe_o, next_addr_out_n_o, next_addr_oe_o;
    logic cache_enable_n_o, bus_hold_n_o, row_path_enable_n_o;
    logic col_path_enable_n_o, col_addr_latch_o, read_data_latch_o;
    logic write_data_latch_o, xcvr_direction_o, xcvr_drive_enable_n_o;
    logic [`NUM_BANKS-1:0] chip_select_n_o, output_enable_n_o, row_strobe_n_o;
    logic parity_row_strobe_n_o, write_enable_latch_clk_o;
    logic latched_addr_strobe_n_o, cycle_pending_n_o;
    logic [`STATE_W-1:0] state_vars_o, st;
    logic [23:0] g, e;
    int error_cnt = 0, n_compared = 0, b;

    always #(`CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    dram_read_ctl dut (.*);

    proc_bus_model cpu (.clk_i(clk_i), .reset_i(reset_i), .go_i(go_req),
        .fill_i(fill_req), .next_addr_out_n_i(next_addr_out_n_o),
        .next_addr_oe_i(next_addr_oe_o), .cache_enable_n_i(cache_enable_n_o),
        .addr_strobe_n_o(addr_strobe_n_i));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(negedge clk_i);
    endtask

    task automatic start();
        go_req <= 1'b1;
        tick();
        go_req <= 1'b0;
    endtask

    task automatic wait_state(input logic [4:0] s);
        int i;
        for (i = 0; i < 40 && state_vars_o !== s; i++) tick();
        cmp(24'(state_vars_o), 24'(s));
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic check_reset();
        g = {row_strobe_n_o, chip_select_n_o, output_enable_n_o,
             byte_write_enables_o, parity_row_strobe_n_o, cycle_pending_n_o,
             bus_hold_n_o, cycle_done_oe_o};
        cmp(g, {12'hFFF, 8'h00, 4'b1110});
        cmp(24'({state_vars_o, next_addr_oe_o}), 24'(6'h00));
    endtask

    task automatic basic_read(input logic [2:0] bk);
        int k;
        logic strb, colp;
        logic [3:0] rs;
        bank_addr_i <= bk;
        col_addr_i <= 10'h2A5 + 10'(bk);
        start();
        wait_state(5'h01);
        cmp(24'(cycle_pending_n_o), 24'h0);
        for (k = 0; k < 10; k++) begin
            strb = k > 0 && k < 6;
            colp = k > 1 && k < 6;
            rs = (strb && !bk[2]) ? ~(4'h1 << bk[1:0]) : 4'hF;
            st = 5'(k < 6 ? k + 1 : (k < 9 ? 7 : 0));
            g = 24'({state_vars_o, row_path_enable_n_o, col_path_enable_n_o,
                     col_addr_latch_o, read_data_latch_o, cycle_done_n_o});
            e = 24'({st, colp, !colp, k == 2, k == 4, k != 5});
            cmp(g, e);
            g = 24'({chip_select_n_o[0], output_enable_n_o[0],
                     parity_row_strobe_n_o, row_strobe_n_o, bus_hold_n_o});
            e = 24'({!colp, !colp, !(strb && !bk[2]), rs, k == 9});
            cmp(g, e);
            g = 24'({xcvr_drive_enable_n_o, xcvr_direction_o,
                     next_addr_out_n_o});
            e = 24'({k != 5, 1'b1, !(k == 2 || k == 4 || k == 5)});
            cmp(g, e);
            if (k == 3) cmp(24'(col_addr_o), 24'(col_addr_i));
            tick();
        end
    endtask

    task automatic basic_write();
        write_not_read_i <= 1'b1;
        bank_addr_i <= 3'h2;
        byte_lane_enables_n_i <= 8'h5A;
        start();
        wait_state(5'h01);
        tick();
        tick();
        g = 24'({state_vars_o, cycle_done_n_o, write_data_latch_o,
                 write_enable_latch_clk_o, read_data_latch_o});
        cmp(g, 24'({5'h0A, 4'b0110}));
        tick();
        g = 24'({state_vars_o, chip_select_n_o, xcvr_drive_enable_n_o,
                 xcvr_direction_o, byte_write_enables_o, 4'h0});
        e = 24'({5'h0B, 4'h0, 2'b00, 8'hA5, 4'h0});
        cmp(g, e);
        write_not_read_i <= 1'b0;
        wait_state(5'h00);
    endtask

    task automatic fill_run(input logic page);
        int i, dones, early_next, cache_hits, broke;
        dones = 0;
        early_next = 0;
        cache_hits = 0;
        broke = 0;
        same_page_i <= page;
        cacheable_i <= 1'b1;
        fill_req <= 1'b1;
        bank_addr_i <= 3'h0;
        start();
        for (i = 0; i < 120; i++) begin
            tick();
            if (dones > 0 && dones < 4 && (row_strobe_n_o[0] !== 1'b0
                || col_path_enable_n_o !== 1'b0)) broke++;
            if (cycle_done_n_o === 1'b0) dones++;
            if (next_addr_out_n_o === 1'b0 && dones == 0) early_next++;
            if (next_addr_out_n_o === 1'b0 && cache_enable_n_o === 1'b0)
                cache_hits++;
        end
        g = 24'({4'(dones), 4'(early_next), cache_hits != 0, broke != 0,
                 state_vars_o, cycle_pending_n_o});
        e = 24'({4'h4, 4'h2, 1'b1, !page, 5'h00, 1'b1});
        cmp(g, e);
        fill_req <= 1'b0;
        cacheable_i <= 1'b0;
    endtask

    task automatic no_decode();
        memory_select_decode_i <= 1'b0;
        start();
        tick();
        cmp(24'(latched_addr_strobe_n_o), 24'h0);
        tick();
        cmp(24'(latched_addr_strobe_n_o), 24'h1);
        repeat (10) tick();
        g = 24'({state_vars_o, cycle_pending_n_o, bus_hold_n_o});
        cmp(g, 24'(7'h03));
        memory_select_decode_i <= 1'b1;
    endtask

    task automatic reset_mid();
        start();
        wait_state(5'h02);
        reset_i <= 1'b1;
        tick();
        reset_i <= 1'b0;
        check_reset();
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (5) tick();
        reset_i <= 1'b0;
        tick();
        check_reset();
        for (b = 0; b < 5; b++) basic_read(3'(b));
        basic_write();
        fill_run(1'b1);
        fill_run(1'b0);
        no_decode();
        reset_mid();
        basic_read(3'h3);
        test_done();
    end

    initial begin
        #(3000 * `CLK_PERIOD_NS);
        error_cnt++;
        test_done();
    end
endmodule // pipelined_dram_read_controller_bench

/* File: tb/proc_bus_model.sv */
// processor bus model issuing address strobes and cache line fills
`timescale 1ns/100ps
module proc_bus_model (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // bench control
    input  wire logic go_i,
    input  wire logic fill_i,
    // controller outputs
    input  wire logic next_addr_out_n_i,
    input  wire logic next_addr_oe_i,
    input  wire logic cache_enable_n_i,
    // strobe to controller
    output logic      addr_strobe_n_o
);
    logic [1:0] left_q;
    logic       armed_q;
    logic       next_seen;
    logic       strobe_n;

    assign next_seen = next_addr_oe_i === 1'b1 && next_addr_out_n_i === 1'b0;

    initial addr_strobe_n_o = 1'b1;

    // one-clock strobe, launched off the falling edge
    always @(negedge clk_i) begin
        strobe_n = 1'b1;
        if (reset_i) begin
            left_q  <= 2'h0;
            armed_q <= 1'b0;
        end else if (go_i) begin
            strobe_n         = 1'b0;
            armed_q         <= fill_i;
            left_q          <= 2'h0;
        end else if (next_seen && armed_q
                     && cache_enable_n_i === 1'b0) begin
            strobe_n         = 1'b0;
            armed_q         <= 1'b0;
            left_q          <= 2'h2;
        end else if (next_seen && left_q != 2'h0) begin
            strobe_n         = 1'b0;
            left_q          <= left_q - 2'h1;
        end
        addr_strobe_n_o <= strobe_n;
    end
endmodule // proc_bus_model
